// File: pkg/qaw_regs.svh
// Purpose: constants of the windowed watchdog fail-safe supervisor
// Assumes: 100 MHz system clock
// Notes:   times in ms, counts derived from the clock rate
`ifndef QAW_REGS_SVH
`define QAW_REGS_SVH
`define QAW_CLK_KHZ        100000
`define QAW_MS_CYCLES      (`QAW_CLK_KHZ)
`define QAW_DEF_WIN_SEL    4'h2
`define QAW_INIT_WIN_MS    256
`define QAW_LFSR_DEFAULT   8'hB2
`define QAW_WDERR_STEP_UP  3'h2
`define QAW_WDERR_MAX      3'h6
`define QAW_RSTERR_MAX     3'h7
`define QAW_FS_LVL_DEF     3'h3
`define QAW_DF_LVL_DEF     3'h6
`define QAW_FS_LVL_ALT     3'h1
`define QAW_DF_LVL_ALT     3'h3
`define QAW_REFRESH_LIMIT  3'h6
`define QAW_RSTREQ_MS      1
`endif

// File: pkg/qaw_pkg.sv
// Purpose: types of the windowed watchdog fail-safe supervisor
// Assumes: nothing
// Notes:   constants live in qaw_regs.svh
package qaw_pkg;
  typedef enum logic [1:0] {QAW_INIT, QAW_RUN, QAW_DEEPFAIL} qaw_phase_t;
  typedef struct packed {
    logic [3:0] windowSel;
    logic       seedValid;
    logic [7:0] seed;
    logic       altEscalation;
    logic       faultToFailsafe;
  } qaw_cfg_t;
  typedef struct packed {
    logic [2:0] watchdogCounterReadout;
    logic [2:0] failsafeDiagnosticTwo;
    logic [2:0] refreshCount;
    logic [7:0] challenge;
  } qaw_stat_t;
endpackage

// File: src/qaw_window_watchdog.sv
// Purpose: question-and-answer window watchdog with error escalation and fault-pair monitor
// Assumes: answers arrive as word+strobe in the link clock domain (spi side)
// Notes:   the link strobe crosses by toggle; fault pins pass three flip-flops
`timescale 1ns/1ps
`include "qaw_regs.svh"

module qaw_window_watchdog (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            linkClk,
  input  wire logic            linkRst,
  input  wire logic            answerStrobe,
  input  wire logic [7:0]      answerWord,
  input  wire qaw_pkg::qaw_cfg_t cfg,
  input  wire logic            faultIndicatorA,
  input  wire logic            faultIndicatorAOe_n,
  input  wire logic            faultIndicatorB,
  input  wire logic            faultIndicatorBOe_n,
  input  wire logic            wakeKey,
  output logic                 reset_request_out_n,
  output logic                 failsafe_output_n,
  output logic                 regulatorsOn,
  output logic                 initPhase,
  output qaw_pkg::qaw_stat_t   status
);

  ////////////////////////////////////////////////////////////////////////
  // link side: capture answer and toggle
  logic [7:0] linkWord;
  logic       linkToggle;
  always_ff @(posedge linkClk or posedge linkRst)
    if (linkRst)
    begin
      linkWord   <= 8'h00;
      linkToggle <= 1'b0;
    end
    else if (answerStrobe)
    begin
      linkWord   <= answerWord;
      linkToggle <= ~linkToggle;
    end

  // word is stable for a whole link period after the toggle; answers must be spaced
  logic [2:0] togSync;
  logic       togSeen;
  logic [2:0] togFill;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      togSync <= 3'h0;
      togSeen <= 1'b0;
      togFill <= 3'h0;
    end
    else
    begin
      togSync <= {togSync[1:0], linkToggle};
      togSeen <= togSync[2];
      if (!togFill[2]) togFill <= togFill + 3'h1;
    end
  // a toggle level left from before a reset of this side must not read as a fresh answer;
  // limitation: an answer landing in the first four cycles after reset is lost
  wire answerEvent = (togSync[2] ^ togSeen) & togFill[2];

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once stages two and three agree
  // undriven pins resolve by the oe bits, as the board pulls do
  wire pinA = faultIndicatorAOe_n ? 1'b0 : faultIndicatorA;
  wire pinB = faultIndicatorBOe_n ? 1'b1 : faultIndicatorB;
  logic [2:0] syncA, syncB, syncK, syncU;
  logic       fltA, fltB, keyLvl, keyPrev, relLvl, faultPrev;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      syncA   <= 3'h0;
      syncB   <= 3'h7;
      syncK   <= 3'h0;
      fltA    <= 1'b0;
      fltB    <= 1'b1;
      keyLvl  <= 1'b0;
      keyPrev <= 1'b0;
      syncU   <= 3'h7;
      relLvl  <= 1'b1;
    end
    else
    begin
      syncA   <= {syncA[1:0], pinA};
      syncB   <= {syncB[1:0], pinB};
      syncK   <= {syncK[1:0], wakeKey};
      if (syncA[1] == syncA[2]) fltA <= syncA[2];
      if (syncB[1] == syncB[2]) fltB <= syncB[2];
      if (syncK[1] == syncK[2]) keyLvl <= syncK[2];
      keyPrev <= keyLvl;
      // release state travels with the pins, so a pair that starts driving shows no pulled levels
      syncU   <= {syncU[1:0], faultIndicatorAOe_n & faultIndicatorBOe_n};
      if (syncU[1] == syncU[2]) relLvl <= syncU[2];
    end
  // pair {b,a}: 01 normal, 10 fault; 00/11 break the bistable pair and count as fault
  wire pairFault  = ~(fltA ^ fltB) | (fltB & ~fltA);
  wire faultNow   = pairFault & ~relLvl;
  wire faultEvent = faultNow & ~faultPrev;
  // one event per fault: a standing fault must not count again every cycle
  always_ff @(posedge clk or posedge rst)
    if (rst)
      faultPrev <= 1'b0;
    else
      faultPrev <= faultNow;
  wire keyRise    = keyLvl & ~keyPrev;

  ////////////////////////////////////////////////////////////////////////
  // window timing
  function automatic logic [10:0] win_ms(input logic [3:0] sel);
    unique case (sel)
      4'h0: win_ms = 11'd1;
      4'h1: win_ms = 11'd2;
      4'h2: win_ms = 11'd3;
      4'h3: win_ms = 11'd4;
      4'h4: win_ms = 11'd8;
      4'h5: win_ms = 11'd16;
      4'h6: win_ms = 11'd32;
      4'h7: win_ms = 11'd64;
      4'h8: win_ms = 11'd128;
      4'h9: win_ms = 11'd256;
      4'hA: win_ms = 11'd512;
      4'hB: win_ms = 11'd1024;
      default: win_ms = 11'd3;
    endcase
  endfunction

  qaw_pkg::qaw_phase_t phase;
  logic [3:0]  windowSel;
  logic [7:0]  lfsr;
  logic        altEsc, faultFs;
  logic [16:0] msTick;
  logic [10:0] msCount;
  logic [2:0]  wdErr, rstErr, refreshCnt;
  logic [16:0] rstReqTimer;
  logic        rstReqPending;

  wire [10:0] winLen     = (phase == qaw_pkg::QAW_INIT) ? 11'(`QAW_INIT_WIN_MS) : win_ms(windowSel);
  wire [10:0] halfLen    = winLen >> 1;
  wire        msEnd      = (msTick == 17'(`QAW_MS_CYCLES - 1));
  wire        periodEnd  = msEnd & (msCount == winLen - 11'd1);
  // the 1 ms window has a half-ms closed part that rounds to zero whole ms
  wire        openHalf   = (phase == qaw_pkg::QAW_INIT) || (msCount >= halfLen);
  wire [7:0]  expected   = ~lfsr;
  wire        running    = (phase != qaw_pkg::QAW_DEEPFAIL);
  wire        goodAns    = running & answerEvent & openHalf & (linkWord == expected);
  wire        badAns     = running & answerEvent & ~goodAns;
  wire        missed     = (phase == qaw_pkg::QAW_RUN) & periodEnd;
  wire        wrongRef   = badAns | missed;
  wire [2:0]  wdErrUp    = (wdErr >= `QAW_WDERR_MAX - `QAW_WDERR_STEP_UP) ? `QAW_WDERR_MAX
                                                                         : wdErr + `QAW_WDERR_STEP_UP;
  wire [2:0]  next_wdErr = wrongRef ? wdErrUp : (goodAns && wdErr != 3'h0) ? wdErr - 3'h1 : wdErr;
  wire        wdTrip     = wrongRef & (wdErrUp == `QAW_WDERR_MAX);
  wire        faultRst   = faultEvent & ~faultFs & running;
  wire        rstEvent   = wdTrip | faultRst;
  wire        relief     = goodAns & (refreshCnt == `QAW_REFRESH_LIMIT);
  wire [2:0]  next_rstErr = rstEvent ? ((rstErr == `QAW_RSTERR_MAX) ? rstErr : rstErr + 3'h1)
                                     : (relief && rstErr != 3'h0) ? rstErr - 3'h1 : rstErr;
  wire [2:0]  fsLevel    = altEsc ? `QAW_FS_LVL_ALT : `QAW_FS_LVL_DEF;
  wire [2:0]  dfLevel    = altEsc ? `QAW_DF_LVL_ALT : `QAW_DF_LVL_DEF;
  wire        enterDeep  = running & (next_rstErr >= dfLevel);
  wire        lfsrFb     = lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3];

  ////////////////////////////////////////////////////////////////////////
  // phase and configuration
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      phase     <= qaw_pkg::QAW_INIT;
      windowSel <= `QAW_DEF_WIN_SEL;
      lfsr      <= `QAW_LFSR_DEFAULT;
      altEsc    <= 1'b0;
      faultFs   <= 1'b0;
    end
    else
    begin
      unique case (phase)
        qaw_pkg::QAW_INIT:
        begin
          windowSel <= cfg.windowSel;
          altEsc    <= cfg.altEscalation;
          faultFs   <= cfg.faultToFailsafe;
          if (enterDeep) phase <= qaw_pkg::QAW_DEEPFAIL;
          else if (goodAns) phase <= qaw_pkg::QAW_RUN;
        end
        qaw_pkg::QAW_RUN:
          if (enterDeep) phase <= qaw_pkg::QAW_DEEPFAIL;
          else if (rstEvent) phase <= qaw_pkg::QAW_INIT;
        qaw_pkg::QAW_DEEPFAIL:
          if (keyRise) phase <= qaw_pkg::QAW_INIT;
      endcase
      if (goodAns) lfsr <= {lfsr[6:0], lfsrFb};
      else if (phase == qaw_pkg::QAW_INIT && cfg.seedValid) lfsr <= cfg.seed;
    end

  ////////////////////////////////////////////////////////////////////////
  // timers and counters
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      msTick  <= 17'h0;
      msCount <= 11'h0;
    end
    else if (answerEvent || periodEnd || rstEvent || !running)
    begin
      msTick  <= 17'h0;
      msCount <= 11'h0;
    end
    else if (msEnd)
    begin
      msTick  <= 17'h0;
      msCount <= msCount + 11'h1;
    end
    else
      msTick  <= msTick + 17'h1;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      wdErr      <= 3'h0;
      rstErr     <= 3'h0;
      refreshCnt <= 3'h0;
    end
    else if (phase == qaw_pkg::QAW_DEEPFAIL)
    begin
      if (keyRise)
      begin
        wdErr      <= 3'h0;
        rstErr     <= 3'h0;
        refreshCnt <= 3'h0;
      end
    end
    else
    begin
      wdErr      <= rstEvent ? 3'h0 : next_wdErr;
      rstErr     <= next_rstErr;
      refreshCnt <= (wrongRef || rstEvent || relief) ? 3'h0 : goodAns ? refreshCnt + 3'h1 : refreshCnt;
    end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all registered
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      rstReqPending <= 1'b0;
      rstReqTimer   <= 17'h0;
    end
    else if (rstEvent && running)
    begin
      rstReqPending <= 1'b1;
      rstReqTimer   <= 17'(`QAW_RSTREQ_MS * `QAW_MS_CYCLES - 1);
    end
    else if (rstReqTimer != 17'h0)
      rstReqTimer   <= rstReqTimer - 17'h1;
    else
      rstReqPending <= 1'b0;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      reset_request_out_n <= 1'b1;
      failsafe_output_n   <= 1'b1;
      regulatorsOn        <= 1'b1;
      initPhase           <= 1'b1;
      status              <= '0;
    end
    else
    begin
      reset_request_out_n <= ~(rstReqPending & running);
      // the wake wins: the count of the old session is still high in that cycle
      if (phase == qaw_pkg::QAW_DEEPFAIL && keyRise) failsafe_output_n <= 1'b1;
      else if (rstErr >= fsLevel || (faultEvent && faultFs)) failsafe_output_n <= 1'b0;
      regulatorsOn        <= running;
      initPhase           <= (phase == qaw_pkg::QAW_INIT);
      status              <= '{watchdogCounterReadout: wdErr, failsafeDiagnosticTwo: rstErr,
                               refreshCount: refreshCnt, challenge: lfsr};
    end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_wderr_step: assert property (@(posedge clk) disable iff (rst)
    (badAns && !rstEvent && wdErr < 3'h4 && running) |=> wdErr == $past(wdErr) + 3'h2)
    else $error("error counter did not rise by two");
  a_wderr_cap: assert property (@(posedge clk) disable iff (rst) wdErr <= 3'h6)
    else $error("error counter above six");
  a_wderr_down: assert property (@(posedge clk) disable iff (rst)
    (goodAns && !rstEvent && wdErr != 3'h0 && running) |=> wdErr == $past(wdErr) - 3'h1)
    else $error("error counter did not fall by one");
  a_trip_reset: assert property (@(posedge clk) disable iff (rst)
    (wdTrip && running && !enterDeep) |-> ##2 !reset_request_out_n)
    else $error("reset request missing after trip");
  a_fs_level: assert property (@(posedge clk) disable iff (rst)
    (rstErr >= fsLevel && !(phase == qaw_pkg::QAW_DEEPFAIL && keyRise)) |=> !failsafe_output_n)
    else $error("fail-safe not asserted at level");
  a_deep_off: assert property (@(posedge clk) disable iff (rst)
    (phase == qaw_pkg::QAW_DEEPFAIL && !keyRise) |=> !regulatorsOn && phase == qaw_pkg::QAW_DEEPFAIL)
    else $error("deep fail left without key");
  a_closed_bad: assert property (@(posedge clk) disable iff (rst)
    (answerEvent && !openHalf) |-> !goodAns)
    else $error("closed window answer accepted");
  a_lfsr_step: assert property (@(posedge clk) disable iff (rst)
    goodAns |=> lfsr != $past(lfsr) && status.challenge == $past(lfsr))
    else $error("challenge did not advance");
  a_init_win: assert property (@(posedge clk) disable iff (rst)
    (phase == qaw_pkg::QAW_INIT) |-> winLen == 11'd256)
    else $error("init window not 256 ms");
  c_good: cover property (@(posedge clk) disable iff (rst) goodAns);
  c_trip: cover property (@(posedge clk) disable iff (rst) wdTrip);
  c_deep: cover property (@(posedge clk) disable iff (rst) phase == qaw_pkg::QAW_DEEPFAIL);
  c_fault: cover property (@(posedge clk) disable iff (rst) faultEvent);
  c_relief: cover property (@(posedge clk) disable iff (rst) relief);
  a_relief_step: assert property (@(posedge clk) disable iff (rst)
    (relief && !rstEvent && rstErr != 3'h0 && running) |=> rstErr == $past(rstErr) - 3'h1)
    else $error("reset error count not relieved");
  a_fault_reset: assert property (@(posedge clk) disable iff (rst)
    (faultRst && !enterDeep) |-> ##2 !reset_request_out_n)
    else $error("reset request missing after fault");
  a_key_wake: assert property (@(posedge clk) disable iff (rst)
    (phase == qaw_pkg::QAW_DEEPFAIL && keyRise) |=> (phase == qaw_pkg::QAW_INIT && failsafe_output_n) ##1 regulatorsOn)
    else $error("key wake did not restart");

endmodule // qaw_window_watchdog

// File: verification/qaw_host_model.sv
// Purpose: host side model: watchdog answers and the bistable fault pair
// Assumes: the link clock runs only while a frame is sent
// Notes:   released pins settle to board pulls, a low and b high
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////
module qaw_host_model (
  input  wire logic  clk,
  output logic       linkClk,
  output logic       answerStrobe,
  output logic [7:0] answerWord,
  output logic       faultIndicatorA,
  output logic       faultIndicatorAOe_n,
  output logic       faultIndicatorB,
  output logic       faultIndicatorBOe_n
);
  logic aLevel;
  // b is always the inverse of a while driven
  assign faultIndicatorA = faultIndicatorAOe_n ? 1'b0 : aLevel;
  assign faultIndicatorB = faultIndicatorBOe_n ? 1'b1 : ~aLevel;
  initial
  begin
    linkClk = 1'b0;
    answerStrobe = 1'b0;
    answerWord = 8'hA5;
    aLevel = 1'b1;
    faultIndicatorAOe_n = 1'b1;
    faultIndicatorBOe_n = 1'b1;
  end
  // one answer per frame; quiet cycles after it keep frames apart
  task automatic send(input logic [7:0] word);
    #37;
    for (int i = 0; i < 4; i++)
    begin
      #80 linkClk = 1'b1;
      #1;
      answerStrobe = (i == 0);
      // word is not left standing once the strobe has been taken
      answerWord = (i == 0) ? word : ~answerWord;
      #79 linkClk = 1'b0;
    end
  endtask
  // mode 0 released (reset or self-test), 1 fault free, 2 fault
  task automatic setFault(input logic [1:0] mode);
    @(posedge clk);
    faultIndicatorAOe_n <= (mode == 2'h0);
    faultIndicatorBOe_n <= (mode == 2'h0);
    aLevel <= (mode == 2'h1);
  endtask
endmodule // qaw_host_model

// File: verification/qa_window_watchdog_failsafe_test.sv
// Purpose: self-checking bench of the window watchdog supervisor
// Assumes: 100 MHz clock, 160 ns link clock made by the host model
// Notes:   early answers give quick wrong refreshes; long windows are not waited out
`timescale 1ns/1ps
`include "qaw_regs.svh"
//////////////////////////////////////////////////////////////////////
module qa_window_watchdog_failsafe_test;
  typedef struct packed {logic [1:0] mode; logic [3:0] exp;} qaw_row_t;
  logic               clk, rst, linkRst, wakeKey, linkClk, answerStrobe;
  logic [7:0]         answerWord, held;
  logic               faultIndicatorA, faultIndicatorAOe_n, faultIndicatorB, faultIndicatorBOe_n;
  logic               reset_request_out_n, failsafe_output_n, regulatorsOn, initPhase;
  qaw_pkg::qaw_cfg_t  cfg;
  qaw_pkg::qaw_stat_t status;
  int                 errors = 0, nTests = 0, cycles = 0;
  // pair released, fault free, fault: expected {reset request, reset error count}
  qaw_row_t           rows [3] = '{'{2'h0, 4'h8}, '{2'h1, 4'h8}, '{2'h2, 4'h1}};

  qaw_window_watchdog qaw_window_watchdog_inst (
    .clk(clk), .rst(rst), .linkClk(linkClk), .linkRst(linkRst),
    .answerStrobe(answerStrobe), .answerWord(answerWord), .cfg(cfg),
    .faultIndicatorA(faultIndicatorA), .faultIndicatorAOe_n(faultIndicatorAOe_n),
    .faultIndicatorB(faultIndicatorB), .faultIndicatorBOe_n(faultIndicatorBOe_n),
    .wakeKey(wakeKey), .reset_request_out_n(reset_request_out_n),
    .failsafe_output_n(failsafe_output_n), .regulatorsOn(regulatorsOn),
    .initPhase(initPhase), .status(status));
  qaw_host_model qaw_host_model_inst (
    .clk(clk), .linkClk(linkClk), .answerStrobe(answerStrobe), .answerWord(answerWord),
    .faultIndicatorA(faultIndicatorA), .faultIndicatorAOe_n(faultIndicatorAOe_n),
    .faultIndicatorB(faultIndicatorB), .faultIndicatorBOe_n(faultIndicatorBOe_n));
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // a run needs a few thousand cycles; this ceiling only catches a hang
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      final_report();
    end
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic answer(input logic good);
    qaw_host_model_inst.send(good ? ~status.challenge : status.challenge);
    ticks(10);
  endtask
  // one good answer leaves init, then three answers in the closed half trip it
  task automatic trip(input int k);
    logic [7:0] old;
    old = status.challenge;
    answer(1'b1);
    check("advance", 8'(status.challenge !== old), 8'h01);
    check("leave init", {7'h00, initPhase}, 8'h00);
    check("wd floor", 8'(status.watchdogCounterReadout), 8'h00);
    answer(1'b0);
    check("wd plus two", 8'(status.watchdogCounterReadout), 8'h02);
    answer(1'b1);
    check("early answer", 8'(status.watchdogCounterReadout), 8'h04);
    answer(1'b1);
    check("reset count", 8'(status.failsafeDiagnosticTwo), 8'(k));
  endtask
  task automatic escalate(input int first, input int fsLvl, input int dfLvl);
    for (int k = first; k <= dfLvl; k++)
    begin
      trip(k);
      check("fail-safe", {7'h00, failsafe_output_n}, 8'(k < fsLvl));
      check("regulators", {7'h00, regulatorsOn}, 8'(k < dfLvl));
      if (k < dfLvl)
        check("trip", {6'h00, initPhase, reset_request_out_n}, 8'h02);
    end
    $display("test escalation to %0d done", dfLvl);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    linkRst = 1'b1;
    wakeKey = 1'b0;
    cfg = '0;
    cfg.windowSel = `QAW_DEF_WIN_SEL;
    ticks(10);
    rst <= 1'b0;
    linkRst <= 1'b0;
    ticks(2);
    check("lfsr default", status.challenge, `QAW_LFSR_DEFAULT);
    check("idle outputs", {4'h0, reset_request_out_n, failsafe_output_n, regulatorsOn, initPhase}, 8'h0F);
    $display("test reset done");
    for (int i = 0; i < 3; i++)
    begin
      qaw_host_model_inst.setFault(rows[i].mode);
      ticks(20);
      check("fault pair", {4'h0, reset_request_out_n, status.failsafeDiagnosticTwo}, 8'(rows[i].exp));
    end
    qaw_host_model_inst.setFault(2'h1);
    $display("test fault pair done");
    // one-ms window: its closed half rounds to nothing, so prompt answers are all good
    cfg.windowSel <= 4'h0;
    for (int i = 0; i < 7; i++)
    begin
      answer(1'b1);
      check("refresh count", 8'(status.refreshCount), 8'((i + 1) % 7));
      check("relief", 8'(status.failsafeDiagnosticTwo), 8'(i < 6));
    end
    repeat (3) answer(1'b0);
    check("back to init", {6'h00, initPhase, reset_request_out_n}, 8'h02);
    check("count after relief", 8'(status.failsafeDiagnosticTwo), 8'h01);
    $display("test relief done");
    cfg.seedValid <= 1'b1;
    cfg.seed <= 8'h5A;
    cfg.windowSel <= 4'hB;
    ticks(5);
    check("seed load", status.challenge, 8'h5A);
    cfg.seedValid <= 1'b0;
    // longest window keeps every early answer well inside the closed half
    escalate(2, 3, 6);
    held = status.challenge;
    answer(1'b1);
    check("deep fail deaf", status.challenge, held);
    wakeKey <= 1'b1;
    ticks(20);
    check("key wake", {6'h00, regulatorsOn, failsafe_output_n}, 8'h03);
    $display("test deep fail done");
    rst <= 1'b1;
    wakeKey <= 1'b0;
    cfg.altEscalation <= 1'b1;
    ticks(2);
    rst <= 1'b0;
    ticks(2);
    escalate(1, 1, 3);
    rst <= 1'b1;
    cfg.altEscalation <= 1'b0;
    cfg.faultToFailsafe <= 1'b1;
    ticks(2);
    rst <= 1'b0;
    ticks(10);
    qaw_host_model_inst.setFault(2'h2);
    ticks(20);
    check("fault to fail-safe", {3'h0, reset_request_out_n, failsafe_output_n, status.failsafeDiagnosticTwo}, 8'h10);
    $display("test fault to fail-safe done");
    final_report();
  end
endmodule // qa_window_watchdog_failsafe_test
